/* File: core/sssl_pkg.sv */
// package: widths, synchroniser depth and timing constants for the serial switch latch
// assumes: a 100 MHz system clock sampling a slow external link clock
package sssl_pkg;
	localparam int WIDTH_WIDE    = 16;
	localparam int WIDTH_NARROW  = 8;
	localparam int SYNC_STAGES   = 2;
	localparam int CLK_SYS_MHZ   = 100;
	localparam int REC_TIME_MS   = 10;
	localparam int REC_CYCLES    = REC_TIME_MS * 1000 * 1000 * CLK_SYS_MHZ / 1000;
	localparam logic [15:0] SHIFT_RESET = 16'h0000;
endpackage

/* File: core/sssl_sync.sv */
// file: two flip-flop synchroniser for one level from outside the clock domain
// assumes: rstn asynchronous active low; rst_val is a constant per instance
`timescale 1ns/1ps
module sssl_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic clk_sys,
	input  wire logic rstn,
	input  wire logic d,
	output logic      q
);
	logic meta_q;

	// first stage is read only by the second stage
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			meta_q <= RST_VAL;
			q      <= RST_VAL;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule // sssl_sync

/* File: core/sssl_top.sv */
// file: serially loaded switch port, shift chain with transfer-frozen parallel outputs
// assumes: link clock, serial data, transfer and clear arrive asynchronously from a controller;
//          pull defaults of undriven pins are modelled by the pad ring, reset values mirror them
`timescale 1ns/1ps

module sssl_top #(
	parameter int WIDTH = sssl_pkg::WIDTH_WIDE
) (
	input  wire logic             clk_sys,
	input  wire logic             rstn,
	input  wire logic             link_clk,
	input  wire logic             serial_in,
	input  wire logic             transfer,
	input  wire logic             clear_n,
	output logic                  readback_out,
	output logic [WIDTH-1:1]      switch_lines
);
	// **********************************
	// input synchronisers
	// **********************************
	logic clk_s;
	logic data_s;
	logic xfer_s;
	logic clr_n_s;
	logic clk_prev_q;
	logic xfer_prev_q;
	logic [WIDTH-1:0] chain_q;

	// reset values match the pin pull defaults
	sssl_sync #(.RST_VAL(1'b0)) u_sync_clk  (.clk_sys(clk_sys), .rstn(rstn), .d(link_clk),  .q(clk_s));
	sssl_sync #(.RST_VAL(1'b0)) u_sync_data (.clk_sys(clk_sys), .rstn(rstn), .d(serial_in), .q(data_s));
	sssl_sync #(.RST_VAL(1'b0)) u_sync_xfer (.clk_sys(clk_sys), .rstn(rstn), .d(transfer),  .q(xfer_s));
	sssl_sync #(.RST_VAL(1'b1)) u_sync_clr  (.clk_sys(clk_sys), .rstn(rstn), .d(clear_n),   .q(clr_n_s));

	// **********************************
	// edge detection
	// **********************************
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			clk_prev_q  <= 1'b0;
			xfer_prev_q <= 1'b0;
		end else begin
			clk_prev_q  <= clk_s;
			xfer_prev_q <= xfer_s;
		end
	end

	logic clk_rise;
	logic xfer_fall;
	assign clk_rise  = clk_s & ~clk_prev_q;
	assign xfer_fall = ~xfer_s & xfer_prev_q;

	// **********************************
	// shift decode
	// **********************************
	// one decode feeds the chain, the readback and the s_shift checks, so they cannot disagree
	function automatic logic f_shift_go(input logic xfer, input logic rise, input logic clr_n);
		return xfer && rise && clr_n;
	endfunction

	// **********************************
	// shift chain
	// **********************************
	// data is synchronised alongside the clock, so equal latency keeps the setup relation
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			chain_q <= sssl_pkg::SHIFT_RESET[WIDTH-1:0];
		end else if (!clr_n_s) begin
			chain_q <= sssl_pkg::SHIFT_RESET[WIDTH-1:0];
		end else if (f_shift_go(xfer_s, clk_rise, clr_n_s)) begin
			chain_q <= {chain_q[WIDTH-2:0], data_s};
		end
	end

	// **********************************
	// outputs
	// **********************************
	// readback sits on the last stage, so old settings stream out as new bits enter
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			readback_out <= 1'b0;
		end else if (!clr_n_s) begin
			readback_out <= 1'b0;
		end else if (f_shift_go(xfer_s, clk_rise, clr_n_s)) begin
			readback_out <= chain_q[WIDTH-2];
		end else begin
			readback_out <= chain_q[WIDTH-1];
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			switch_lines <= '0;
		end else if (!clr_n_s) begin
			switch_lines <= '0;
		end else if (xfer_fall) begin
			switch_lines <= chain_q[WIDTH-2:0];
		end
	end

	// **********************************
	// assertions
	// **********************************
	sequence s_shift;
		f_shift_go(xfer_s, clk_rise, clr_n_s);
	endsequence

	sequence s_idle;
		!xfer_s && clr_n_s;
	endsequence

	sequence s_clear;
		!clr_n_s;
	endsequence

	// **********************************
	// shift chain checks
	// **********************************
	a_shift_gate: assert property (@(posedge clk_sys) disable iff (!rstn)
		s_idle
		|=> $stable(chain_q))
		else $error("chain moved while transfer low");

	a_shift_data: assert property (@(posedge clk_sys) disable iff (!rstn)
		s_shift
		|=> chain_q[0] == $past(data_s))
		else $error("shifted bit not sampled data");

	a_shift_move: assert property (@(posedge clk_sys) disable iff (!rstn)
		s_shift
		|=> chain_q[WIDTH-1:1] == $past(chain_q[WIDTH-2:0]))
		else $error("chain did not advance");

	a_chain_cause: assert property (@(posedge clk_sys) disable iff (!rstn)
		$changed(chain_q)
		|-> ($past(xfer_s) && $past(clk_rise)) || !$past(clr_n_s))
		else $error("chain moved without a shift or clear");

	a_rise_single: assert property (@(posedge clk_sys) disable iff (!rstn)
		clk_rise
		|=> !clk_rise)
		else $error("one link edge seen twice");

	// **********************************
	// output checks
	// **********************************
	a_lines_frozen: assert property (@(posedge clk_sys) disable iff (!rstn)
		(xfer_s && clr_n_s)
		|=> $stable(switch_lines))
		else $error("switch lines moved during transfer");

	a_lines_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
		(!xfer_fall && clr_n_s)
		|=> $stable(switch_lines))
		else $error("switch lines moved without transfer fall");

	a_lines_load: assert property (@(posedge clk_sys) disable iff (!rstn)
		(xfer_fall && clr_n_s)
		|=> switch_lines == $past(chain_q[WIDTH-2:0]))
		else $error("switch lines not loaded on transfer fall");

	a_lines_cause: assert property (@(posedge clk_sys) disable iff (!rstn)
		$changed(switch_lines)
		|-> $past(xfer_fall) || !$past(clr_n_s))
		else $error("switch lines moved without a cause");

	a_fall_single: assert property (@(posedge clk_sys) disable iff (!rstn)
		xfer_fall
		|=> !xfer_fall)
		else $error("one transfer fall seen twice");

	a_readback_tail: assert property (@(posedge clk_sys) disable iff (!rstn)
		clr_n_s ##1 clr_n_s
		|-> readback_out == chain_q[WIDTH-1])
		else $error("readback not final stage");

	a_readback_walk: assert property (@(posedge clk_sys) disable iff (!rstn)
		s_shift ##1 clr_n_s
		|-> readback_out == $past(chain_q[WIDTH-2], 1))
		else $error("readback did not follow shift");

	a_readback_idle: assert property (@(posedge clk_sys) disable iff (!rstn)
		s_idle ##1 s_idle
		|-> $stable(readback_out))
		else $error("readback moved while transfer low");

	a_readback_cause: assert property (@(posedge clk_sys) disable iff (!rstn)
		$changed(readback_out)
		|-> ($past(xfer_s) && $past(clk_rise)) || !$past(clr_n_s))
		else $error("readback moved without a shift or clear");

	// **********************************
	// clear checks
	// **********************************
	a_clear_low: assert property (@(posedge clk_sys) disable iff (!rstn)
		s_clear
		|=> (switch_lines == '0 && readback_out == 1'b0 && chain_q == '0))
		else $error("clear did not force outputs low");

	a_clear_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
		s_clear ##1 s_clear
		|=> (switch_lines == '0 && readback_out == 1'b0))
		else $error("outputs rose while clear held");
endmodule // sssl_top

/* File: dv/sssl_ctl_model.sv */
// file: behavioural serial controller that loads the switch latch
// assumes: the caller waits out reset before the first frame
`timescale 1ns/1ps
module sssl_ctl_model (
	output logic link_clk,
	output logic serial_in,
	output logic transfer
);
	initial begin
		link_clk  = 1'b0;
		serial_in = 1'b0;
		transfer  = 1'b0;
	end
	// first bit ends deepest; clock idles low outside frames
	task automatic shift(input logic [15:0] w, input int n, input logic t);
		transfer = t;
		#125;
		for (int i = n - 1; i >= 0; i--) begin
			serial_in = w[i];
			#62.5 link_clk = 1'b1;
			#62.5 link_clk = 1'b0;
		end
		serial_in = ~serial_in;
		#125;
	endtask
	task automatic drop();
		transfer  = 1'b0;
		serial_in = ~serial_in;
		#125;
	endtask
endmodule // sssl_ctl_model

/* File: dv/tb_sssl_top.sv */
// file: self-checking bench for the serial switch latch, wide and narrow variants side by side
// assumes: sssl_ctl_model drives the link; no registers or interrupts
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
	$display("[ERR] %s exp %h got %h", n, e, a); end end
module tb_sssl_top;
	logic        clk_sys      = 1'b0;
	logic        rstn         = 1'b0;
	logic        clear_n      = 1'b1;
	logic        link_clk;
	logic        serial_in;
	logic        transfer;
	logic        readback_out;
	logic [15:1] switch_lines;
	logic        readback_nar;
	logic [7:1]  lines_nar;
	logic [15:0] prev         = 16'h0000;
	int          bad_count    = 0;
	int          checks_done  = 0;
	logic [15:0] rows [4]     = '{16'hA5C3, 16'hFFFF, 16'h0000, 16'h1E69};
	always #5 clk_sys = ~clk_sys;
	sssl_ctl_model ctl_u (.link_clk(link_clk), .serial_in(serial_in), .transfer(transfer));
	sssl_top #(.WIDTH(16)) dut_u (.clk_sys(clk_sys), .rstn(rstn), .link_clk(link_clk), .serial_in(serial_in),
		.transfer(transfer), .clear_n(clear_n), .readback_out(readback_out), .switch_lines(switch_lines));
	sssl_top #(.WIDTH(8)) dut_n (.clk_sys(clk_sys), .rstn(rstn), .link_clk(link_clk), .serial_in(serial_in),
		.transfer(transfer), .clear_n(clear_n), .readback_out(readback_nar), .switch_lines(lines_nar));
	task automatic stop_test();
		$display("checks %0d errors %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// inputs pass two-flop syncs: look well after the latency, not at it
	task automatic settle();
		repeat (10) @(negedge clk_sys);
	endtask
	initial begin
		#200000;
		bad_count++;
		stop_test();
	end
	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		repeat (6) @(negedge clk_sys);
		rstn = 1'b1;
		`CHK("lines after reset", 15'h0000, switch_lines)
		`CHK("narrow after reset", 7'h00, lines_nar)
		// recovery wait scaled down to fit the run; the link stays idle meanwhile
		repeat (4) @(negedge clk_sys);
		foreach (rows[r]) begin
			ctl_u.shift(rows[r], 16, 1'b1);
			`CHK("lines frozen", prev[14:0], switch_lines)
			`CHK("narrow frozen", prev[6:0], lines_nar)
			`CHK("readback", rows[r][15], readback_out)
			`CHK("narrow readback", rows[r][7], readback_nar)
			ctl_u.drop();
			settle();
			`CHK("lines loaded", rows[r][14:0], switch_lines)
			`CHK("narrow loaded", rows[r][6:0], lines_nar)
			prev = rows[r];
		end
		ctl_u.shift(16'h0001, 1, 1'b1);
		`CHK("readback one shift", prev[14], readback_out)
		`CHK("narrow one shift", prev[6], readback_nar)
		`CHK("lines mid frame", prev[14:0], switch_lines)
		@(negedge clk_sys);
		clear_n = 1'b0;
		settle();
		`CHK("lines cleared", 15'h0000, switch_lines)
		`CHK("readback cleared", 1'b0, readback_out)
		`CHK("narrow cleared", 7'h00, lines_nar)
		clear_n = 1'b1;
		ctl_u.drop();
		settle();
		`CHK("chain emptied", 15'h0000, switch_lines)
		ctl_u.shift(16'hFFFF, 16, 1'b0);
		settle();
		`CHK("lines ignore clock", 15'h0000, switch_lines)
		`CHK("narrow ignore clock", 7'h00, lines_nar)
		`CHK("readback ignore clock", 1'b0, readback_out)
		stop_test();
	end
endmodule // tb_sssl_top
